// File: eph_ctrl.sv
// eph_ctrl: drives the strobes, address and data pins of a parallel eeprom to
// read, page write, and enter or leave software write protection, then waits
// for the end of the internal write by toggle and polling status reads.
// assumes pins are sampled synchronously and that nothing else drives the bus.
//
// Functional notes
// - Code bytes use the eight data lines and code addresses all thirteen address lines.
// - Zero to 64 bytes may follow a protection sequence and one to 64 a plain page write.
// - The page address lines hold one value at every falling write strobe after the code.
// - In writes the output strobe is high only while write strobe and chip select are low.
// - All polling reads use one unchanged address, the last one written.
// - Each next byte load starts inside the byte load window, else the load phase closes.
`timescale 1ns/1ps
module eph_ctrl
  import eph_pkg::*;
#(
  parameter int BLC_CYCLES = BLC_CYC,
  parameter int POLL_CYCLES = WC_CYC,
  parameter logic [ADDR_W-1:0] SEQ_ADDR_A = 13'h1555,
  parameter logic [ADDR_W-1:0] SEQ_ADDR_B = 13'h0aaa,
  parameter logic [DATA_W-1:0] SEQ_CODE_A = 8'haa,
  parameter logic [DATA_W-1:0] SEQ_CODE_B = 8'h55,
  parameter logic [DATA_W-1:0] SEQ_CODE_ON = 8'ha0,
  parameter logic [DATA_W-1:0] SEQ_CODE_OFF = 8'h80,
  parameter logic [DATA_W-1:0] SEQ_CODE_OFF2 = 8'h20
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // command port
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic [1:0] cmd_op_i,
  input wire logic [ADDR_W-1:0] cmd_addr_i,
  // page data stream
  input wire logic wr_valid_i,
  output logic wr_ready_o,
  input wire logic [OFFS_W-1:0] wr_offset_i,
  input wire logic [DATA_W-1:0] wr_data_i,
  input wire logic wr_last_i,
  // results
  output logic [DATA_W-1:0] rd_data_o,
  output logic done_o,
  output logic error_o,
  output logic busy_o,
  // eeprom pins
  output logic [ADDR_W-1:0] addr_o,
  output logic [DATA_W-1:0] data_o,
  output logic data_oe_o,
  input wire logic [DATA_W-1:0] data_i,
  output logic ce_b_o,
  output logic oe_b_o,
  output logic we_b_o
);

  localparam int GAP_W = 18;
  localparam int POLL_W = 24;
  localparam logic [GAP_W-1:0] GAP_CLOSE = GAP_W'(BLC_CYCLES - WP_CYC - WPH_CYC - 2);
  localparam logic [GAP_W-1:0] GAP_EXPIRE = GAP_W'(BLC_CYCLES + 1);
  localparam logic [POLL_W-1:0] POLL_LIMIT = POLL_W'(POLL_CYCLES);
  localparam logic [3:0] WP_LAST = 4'(WP_CYC - 1);
  localparam logic [3:0] WPH_LAST = 4'(WPH_CYC - 1);
  localparam logic [3:0] RD_LAST = 4'(RD_CYC - 1);
  localparam logic [3:0] OEHP_LAST = 4'(OEHP_CYC - 1);
  localparam logic [6:0] PAGE_FULL = 7'(PAGE_BYTES);

  eph_state_t state;
  logic [1:0] op;
  logic [PAGE_W-1:0] page;
  logic [2:0] seq_idx;
  logic [2:0] seq_len;
  logic [6:0] nbytes;
  logic last_seen;
  logic loaded;
  logic last_bit7;
  logic have_prev;
  logic prev_toggle;
  logic err;
  logic [3:0] cnt;
  logic [GAP_W-1:0] gap;
  logic [POLL_W-1:0] poll_cnt;
  logic [ADDR_W-1:0] seq_addr;
  logic [DATA_W-1:0] seq_data;
  logic toggle_same;
  logic poll_true;

  // command table: step index selects address and code
  always_comb begin
    seq_addr = SEQ_ADDR_A;
    seq_data = SEQ_CODE_A;
    case (seq_idx)
      3'h1, 3'h4: begin
        seq_addr = SEQ_ADDR_B;
        seq_data = SEQ_CODE_B;
      end
      3'h2: seq_data = (op == OP_PROT_ON) ? SEQ_CODE_ON : SEQ_CODE_OFF;
      3'h5: seq_data = SEQ_CODE_OFF2;
      default: begin
        seq_addr = SEQ_ADDR_A;
        seq_data = SEQ_CODE_A;
      end
    endcase
  end

  assign toggle_same = have_prev && (prev_toggle == rd_data_o[TOGGLE_BIT]);
  assign poll_true = !loaded || (rd_data_o[POLL_BIT] == last_bit7);

  // handshakes and pins decode straight from the one-hot state
  assign cmd_ready_o = (state == ST_IDLE);
  assign wr_ready_o = (state == ST_GAP);
  assign busy_o = (state != ST_IDLE);
  assign done_o = (state == ST_DONE);
  assign error_o = (state == ST_DONE) && err;
  assign ce_b_o = !(state == ST_WLOW || state == ST_RLOW);
  assign we_b_o = !(state == ST_WLOW);
  // output strobe is high during the write pulse and after each read access; idle low is harmless with chip select high
  assign oe_b_o = (state == ST_WLOW) || (state == ST_RHIGH);
  assign data_oe_o = (state == ST_WLOW) || (state == ST_WHIGH);

  // main sequencer
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= ST_IDLE;
      op <= OP_READ;
      page <= '0;
      seq_idx <= 3'h0;
      seq_len <= 3'h0;
      nbytes <= 7'h00;
      last_seen <= 1'b0;
      loaded <= 1'b0;
      last_bit7 <= 1'b0;
      have_prev <= 1'b0;
      prev_toggle <= 1'b0;
      err <= 1'b0;
      addr_o <= '0;
      data_o <= '0;
      rd_data_o <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (cmd_valid_i) begin
            op <= cmd_op_i;
            page <= cmd_addr_i[ADDR_W-1:OFFS_W];
            nbytes <= 7'h00;
            last_seen <= 1'b0;
            loaded <= 1'b0;
            have_prev <= 1'b0;
            err <= 1'b0;
            seq_idx <= 3'h0;
            if (cmd_op_i == OP_READ) begin
              addr_o <= cmd_addr_i;
              state <= ST_RLOW;
            end else if (cmd_op_i == OP_WRITE) begin
              seq_len <= 3'h0;
              state <= ST_GAP;
            end else begin
              seq_len <= (cmd_op_i == OP_PROT_ON) ? SEQ_LEN_ON : SEQ_LEN_OFF;
              addr_o <= SEQ_ADDR_A;
              data_o <= SEQ_CODE_A;
              seq_idx <= 3'h1;
              state <= ST_WLOW;
            end
          end
        end
        ST_WLOW: begin
          if (cnt == WP_LAST) begin
            state <= ST_WHIGH;
          end
        end
        ST_WHIGH: begin
          if (cnt == WPH_LAST) begin
            if (seq_idx < seq_len) begin
              addr_o <= seq_addr;
              data_o <= seq_data;
              seq_idx <= seq_idx + 3'h1;
              state <= ST_WLOW;
            end else if (last_seen || nbytes == PAGE_FULL) begin
              state <= ST_SETTLE;
            end else begin
              state <= ST_GAP;
            end
          end
        end
        ST_GAP: begin
          if (wr_valid_i) begin
            addr_o <= {page, wr_offset_i};
            data_o <= wr_data_i;
            last_bit7 <= wr_data_i[POLL_BIT];
            loaded <= 1'b1;
            nbytes <= nbytes + 7'h01;
            last_seen <= wr_last_i;
            state <= ST_WLOW;
          end else if (gap >= GAP_CLOSE && !(op == OP_WRITE && nbytes == 7'h00)) begin
            state <= ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          // let the device's own load window lapse so its internal write has begun
          if (gap >= GAP_EXPIRE) begin
            state <= ST_RLOW;
          end
        end
        ST_RLOW: begin
          if (cnt == RD_LAST) begin
            rd_data_o <= data_i;
            state <= ST_RHIGH;
          end
        end
        ST_RHIGH: begin
          if (cnt == OEHP_LAST) begin
            state <= (op == OP_READ) ? ST_DONE : ST_CHECK;
          end
        end
        ST_CHECK: begin
          if (toggle_same && poll_true) begin
            state <= ST_DONE;
          end else if (poll_cnt >= POLL_LIMIT) begin
            err <= 1'b1;
            state <= ST_DONE;
          end else begin
            prev_toggle <= rd_data_o[TOGGLE_BIT];
            have_prev <= 1'b1;
            state <= ST_RLOW;
          end
        end
        ST_DONE: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // strobe phase timer, restarted on every phase change
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt <= 4'h0;
    end else if ((state == ST_WLOW && cnt == WP_LAST) || (state == ST_WHIGH && cnt == WPH_LAST)
                 || (state == ST_RLOW && cnt == RD_LAST)
                 || (state == ST_RHIGH && cnt == OEHP_LAST)
                 || !(state == ST_WLOW || state == ST_WHIGH || state == ST_RLOW
                      || state == ST_RHIGH)) begin
      cnt <= 4'h0;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end

  // load window timer, measured from the latest falling write strobe
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gap <= '0;
    end else if (state == ST_WLOW && cnt == 4'h0) begin
      gap <= '0;
    end else if (gap != {GAP_W{1'b1}}) begin
      gap <= gap + GAP_W'(1);
    end
  end

  // bound on the whole command, counted from leaving idle, so a dead part cannot hang the host
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      poll_cnt <= '0;
    end else if (state == ST_IDLE) begin
      poll_cnt <= '0;
    end else if (poll_cnt != {POLL_W{1'b1}}) begin
      poll_cnt <= poll_cnt + POLL_W'(1);
    end
  end

endmodule

// File: eph_pkg.sv
// eph_pkg: constants for the host-side page write / protection controller.
// assumes a 50 MHz system clock and a byte-wide parallel eeprom on the far side.
package eph_pkg;

  // clock
  localparam int CLK_PERIOD_NS = 20;

  // pin timing as printed, in its own unit
  localparam int WRITE_PULSE_NS = 100;
  localparam int WRITE_HIGH_NS = 50;
  localparam int READ_ACCESS_NS = 120;
  localparam int OUT_STROBE_HIGH_NS = 150;
  localparam int BYTE_LOAD_WINDOW_US = 150;
  localparam int WRITE_CYCLE_MS = 2;

  // least times round up, the two longest times round down
  localparam int WP_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WPH_CYC = (WRITE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RD_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OEHP_CYC = (OUT_STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLC_CYC = (BYTE_LOAD_WINDOW_US * 1000) / CLK_PERIOD_NS;
  localparam int WC_CYC = (WRITE_CYCLE_MS * 1000000) / CLK_PERIOD_NS;

  // bus geometry
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int OFFS_W = 6;
  localparam int PAGE_W = ADDR_W - OFFS_W;
  localparam int PAGE_BYTES = 64;
  localparam int TOGGLE_BIT = 6;
  localparam int POLL_BIT = 7;

  // user commands
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_PROT_ON = 2'h2;
  localparam logic [1:0] OP_PROT_OFF = 2'h3;

  // command sequence lengths
  localparam logic [2:0] SEQ_LEN_ON = 3'h3;
  localparam logic [2:0] SEQ_LEN_OFF = 3'h6;

  typedef enum logic [8:0] {
    ST_IDLE   = 9'h001,
    ST_WLOW   = 9'h002,
    ST_WHIGH  = 9'h004,
    ST_GAP    = 9'h008,
    ST_SETTLE = 9'h010,
    ST_RLOW   = 9'h020,
    ST_RHIGH  = 9'h040,
    ST_CHECK  = 9'h080,
    ST_DONE   = 9'h100
  } eph_state_t;

endpackage

// File: eph_monitor.sv
// eph_monitor: pin protocol checks for eph_ctrl.
// assumes it is bound into eph_ctrl and sees its ports only.
`timescale 1ns/1ps
module eph_monitor
  import eph_pkg::*;
#(
  parameter int BLC_CYCLES = BLC_CYC
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // command side
  input wire logic cmd_valid_i,
  input wire logic cmd_ready_o,
  input wire logic [1:0] cmd_op_i,
  input wire logic [ADDR_W-1:0] cmd_addr_i,
  input wire logic done_o,
  // eeprom pins
  input wire logic [ADDR_W-1:0] addr_o,
  input wire logic [DATA_W-1:0] data_o,
  input wire logic ce_b_o,
  input wire logic oe_b_o,
  input wire logic we_b_o
);
  default clocking mclk @(posedge clock_i);
  endclocking
  default disable iff (!rst_b_i);
  logic [1:0] op;
  logic [6:0] cpg;
  logic [2:0] nf;
  logic [ADDR_W-1:0] lwa;
  logic we_q;
  int gcnt;
  logic [2:0] sl;
  assign sl = (op == OP_PROT_ON) ? SEQ_LEN_ON : (op == OP_PROT_OFF) ? SEQ_LEN_OFF : 3'h0;
  // nf saturates at 7, which is past the longest code sequence
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      op <= 2'h0;
      cpg <= 7'h00;
      nf <= 3'h0;
      lwa <= 13'h0000;
      we_q <= 1'b1;
      gcnt <= 0;
    end else begin
      we_q <= we_b_o;
      gcnt <= gcnt + 1;
      if (cmd_valid_i && cmd_ready_o) begin
        op <= cmd_op_i;
        cpg <= cmd_addr_i[12:6];
        nf <= 3'h0;
      end
      if (we_q && !we_b_o) begin
        lwa <= addr_o;
        gcnt <= 0;
        nf <= (nf == 3'h7) ? nf : nf + 3'h1;
      end
    end
  end
  sequence s_wlow;
    !we_b_o && !ce_b_o && oe_b_o;
  endsequence
  sequence s_rlow;
    !ce_b_o && !oe_b_o && we_b_o;
  endsequence
  chk_write_pulse: assert property ($fell(we_b_o) |->
    s_wlow [*5] ##1 (we_b_o && !oe_b_o) [*3])
    else $error("write strobe shape wrong");
  chk_seq_bytes: assert property ($fell(we_b_o) && nf < sl |->
    addr_o == ((nf == 3'h1 || nf == 3'h4) ? 13'h0aaa : 13'h1555) && data_o ==
    ((nf == 3'h0 || nf == 3'h3) ? 8'haa : (nf == 3'h1 || nf == 3'h4) ? 8'h55 :
    (nf == 3'h5) ? 8'h20 : (op == OP_PROT_ON) ? 8'ha0 : 8'h80))
    else $error("code byte wrong");
  chk_page_hold: assert property ($fell(we_b_o) && nf >= sl |-> addr_o[12:6] == cpg)
    else $error("page moved");
  chk_load_window: assert property ($fell(we_b_o) && nf != 3'h0 |-> gcnt < BLC_CYCLES)
    else $error("byte load too late");
  chk_poll_addr: assert property ($fell(ce_b_o) && we_b_o && nf != 3'h0 |->
    addr_o == lwa)
    else $error("poll address moved");
  chk_read_pulse: assert property ($fell(ce_b_o) && we_b_o |->
    s_rlow [*6] ##1 (ce_b_o && oe_b_o) [*8])
    else $error("read strobe shape wrong");
  chk_done_idle: assert property (done_o |->
    ce_b_o && we_b_o && !cmd_ready_o ##1 cmd_ready_o)
    else $error("done without idle");
  chk_read_done: assert property (cmd_valid_i && cmd_ready_o && cmd_op_i == OP_READ |->
    ##15 done_o)
    else $error("read late");
endmodule

// File: eph_eeprom_model.sv
// eph_eeprom_model: behavioural eeprom with page load, protection codes, status bits.
// assumes one clocked host; the off code is matched on its last three bytes only.
`timescale 1ns/1ps
module eph_eeprom_model
  import eph_pkg::*;
#(
  parameter int BLC = 40,
  parameter int WR = 300
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // bus pins
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] din_i,
  input wire logic ce_b_i,
  input wire logic oe_b_i,
  input wire logic we_b_i,
  output logic [DATA_W-1:0] dout_o
);
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic [20:0] h1, h2;
  logic we_q, rd_q, prot, pend, unlk, load, busy, tog, b7;
  logic [DATA_W-1:0] lastv;
  int lcnt;
  int wcnt;
  logic rd;
  logic cmd;
  assign rd = !ce_b_i && !oe_b_i && we_b_i;
  assign cmd = addr_i == 13'h1555 || addr_i == 13'h0aaa;
  // a released bus shows the inverse of its last value
  assign dout_o = !rd ? ~lastv : busy ? {~b7, tog, 6'h15}
                  : cmd ? 8'hff : mem[addr_i];
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      {h1, h2} <= '0;
      {we_q, rd_q, prot, pend, unlk, load, busy, tog, b7} <= 9'h100;
      lastv <= 8'h00;
      lcnt <= 0;
      wcnt <= 0;
    end else begin
      we_q <= we_b_i;
      rd_q <= rd;
      lcnt <= lcnt + 1;
      wcnt <= wcnt + 1;
      if (rd)
        lastv <= dout_o;
      if (rd && !rd_q && busy)
        tog <= !tog;
      if (we_q && !we_b_i && !ce_b_i && !busy) begin
        h2 <= h1;
        h1 <= {addr_i, din_i};
        load <= 1'b1;
        lcnt <= 0;
        b7 <= din_i[7];
        if (h2 == 21'h1555aa && h1 == 21'h0aaa55 && {addr_i, din_i} == 21'h1555a0) begin
          pend <= 1'b1;
          unlk <= 1'b1;
        end
        if (h2 == 21'h1555aa && h1 == 21'h0aaa55 && {addr_i, din_i} == 21'h155520) begin
          pend <= 1'b0;
          unlk <= 1'b1;
        end
        if (!cmd && (!prot || unlk))
          mem[addr_i] <= din_i;
      end
      if (load && lcnt == BLC - 1) begin
        load <= 1'b0;
        busy <= 1'b1;
        wcnt <= 0;
      end
      if (busy && wcnt == WR) begin
        busy <= 1'b0;
        prot <= pend;
        unlk <= 1'b0;
      end
    end
  end
endmodule

// File: tb.sv
// tb: self-checking bench for eph_ctrl against the eeprom model.
// assumes eph_pkg, eph_monitor and eph_eeprom_model compile first.
`timescale 1ns/1ps
module tb;
  import eph_pkg::*;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic cmd_valid = 1'b0;
  logic [1:0] cmd_op = 2'h0;
  logic [ADDR_W-1:0] cmd_addr = 13'h0000;
  logic wr_valid = 1'b0;
  logic [OFFS_W-1:0] wr_offset = 6'h00;
  logic [DATA_W-1:0] wr_data = 8'h00;
  logic wr_last = 1'b0;
  logic cmd_ready, wr_ready, done, error, busy, data_oe, ce_b, oe_b, we_b, err;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] rd_data, hdata, edata, bus;
  int fails = 0;
  int total_checks = 0;
  always #10 clock_i = ~clock_i;
  assign bus = data_oe ? hdata : edata;
  eph_ctrl #(.BLC_CYCLES(40), .POLL_CYCLES(2000)) dut (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_op_i(cmd_op), .cmd_addr_i(cmd_addr),
    .wr_valid_i(wr_valid), .wr_ready_o(wr_ready), .wr_offset_i(wr_offset), .wr_data_i(wr_data),
    .wr_last_i(wr_last), .rd_data_o(rd_data), .done_o(done), .error_o(error), .busy_o(busy),
    .addr_o(addr), .data_o(hdata), .data_oe_o(data_oe), .data_i(bus), .ce_b_o(ce_b),
    .oe_b_o(oe_b), .we_b_o(we_b));
  eph_eeprom_model #(.BLC(40), .WR(300)) u_mem (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .addr_i(addr), .din_i(bus), .ce_b_i(ce_b), .oe_b_i(oe_b), .we_b_i(we_b), .dout_o(edata));
  function automatic bit miss(input bit eq);
    total_checks++;
    return !eq;
  endfunction
  task automatic bad(input string m);
    fails++;
    $display("ERROR %0t %s", $time, m);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic op_run(input logic [1:0] op, input logic [ADDR_W-1:0] a, input int n,
                        input logic [DATA_W-1:0] d0);
    @(posedge clock_i);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= a;
    do @(negedge clock_i); while (cmd_ready !== 1'b1);
    @(posedge clock_i);
    cmd_valid <= 1'b0;
    for (int i = 0; i < n; i++) begin
      wr_valid <= 1'b1;
      wr_offset <= a[5:0] + OFFS_W'(i);
      wr_data <= d0 + DATA_W'(i);
      wr_last <= (i == n - 1);
      do @(negedge clock_i); while (wr_ready !== 1'b1);
      @(posedge clock_i);
    end
    wr_valid <= 1'b0;
    err = 1'b0;
    do begin
      @(negedge clock_i);
      err = err | (error === 1'b1);
    end while (done !== 1'b1);
    if (miss(err === 1'b0)) bad("end of write not seen");
    if (miss(busy === 1'b1 && cmd_ready === 1'b0)) bad("busy not shown at done");
  endtask
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    op_run(OP_READ, a, 0, 8'h00);
    if (miss(rd_data === e)) bad("read data mismatch");
  endtask
  task automatic s_full_page;
    op_run(OP_WRITE, 13'h1000, 64, 8'h00);
    rd_chk(13'h1000, 8'h00);
    rd_chk(13'h103f, 8'h3f);
  endtask
  task automatic s_prot_on;
    op_run(OP_WRITE, 13'h0201, 1, 8'h81);
    op_run(OP_PROT_ON, 13'h0400, 0, 8'h00);
    op_run(OP_WRITE, 13'h0201, 1, 8'h92);
    rd_chk(13'h0201, 8'h81);
  endtask
  task automatic s_prot_data;
    op_run(OP_PROT_ON, 13'h0200, 3, 8'h10);
    rd_chk(13'h0202, 8'h12);
  endtask
  task automatic s_prot_off;
    op_run(OP_PROT_OFF, 13'h0400, 0, 8'h00);
    op_run(OP_WRITE, 13'h0201, 1, 8'hc4);
    rd_chk(13'h0201, 8'hc4);
  endtask
  initial begin
    repeat (8) @(posedge clock_i);
    rst_b_i <= 1'b1;
    @(negedge clock_i);
    if (miss(cmd_ready === 1'b1 && busy === 1'b0)) bad("not idle after reset");
    if (miss({ce_b, we_b, oe_b, data_oe, done, wr_ready} === 6'h30)) bad("pins not idle");
    s_full_page();
    s_prot_on();
    s_prot_data();
    s_prot_off();
    end_sim();
  end
  initial begin
    repeat (50000) @(posedge clock_i);
    fails++;
    $display("ERROR %0t watchdog expired", $time);
    end_sim();
  end
endmodule
bind eph_ctrl eph_monitor #(.BLC_CYCLES(BLC_CYCLES)) u_mon (.clock_i(clock_i),
  .rst_b_i(rst_b_i), .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
  .cmd_op_i(cmd_op_i), .cmd_addr_i(cmd_addr_i), .done_o(done_o), .addr_o(addr_o),
  .data_o(data_o), .ce_b_o(ce_b_o), .oe_b_o(oe_b_o), .we_b_o(we_b_o));
